// ==== apb_ctrl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module apb_ctrl_host (
    // Clock
    input  wire logic                           clk_in,
    // APB master side
    output logic                                psel_out,
    output logic                                penable_out,
    output logic                                pwrite_out,
    output logic [counter_pkg::ADDR_W-1:0]      paddr_out,
    output logic [31:0]                         pwdata_out,
    input  wire logic [31:0]                    prdata_in,
    input  wire logic                           pready_in,
    input  wire logic                           pslverr_in
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = '0;
        pwdata_out = 32'h0;
    end

    // ------------------------------------------------------------------
    // One transfer; held until pready is seen, no cycle count assumed
    // ------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic er);
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        rd = prdata_in;
        er = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== count_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module count_prescaler
    import counter_pkg::*;
#(
    parameter int WIDTH = counter_pkg::PRESCALE_W
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    // Control
    input  wire logic             run_in,
    input  wire logic [WIDTH-1:0] reload_in,
    // Count clock enable
    output logic                  tick_out
);

    logic [WIDTH-1:0] div_r;

    // ------------------------------------------------------------------
    // Divider: one tick every reload+1 cycles
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in || !run_in) begin
            div_r    <= '0;
            tick_out <= 1'b0;
        end else if (div_r >= reload_in) begin
            div_r    <= '0;
            tick_out <= 1'b1;
        end else begin
            div_r    <= div_r + 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== counter_pkg.sv ====
`default_nettype none
package counter_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_PRESET    = 8'h04;
    localparam logic [7:0]  OFF_PRESCALE  = 8'h08;
    localparam logic [7:0]  OFF_STEP      = 8'h0C;
    localparam logic [7:0]  OFF_STATUS    = 8'h10;
    localparam logic [7:0]  OFF_COUNT_ALL = 8'h14;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int          CTRL_CLEAR_N  = 0;
    localparam int          CTRL_LOAD_N   = 1;
    localparam int          CTRL_PGATE    = 2;
    localparam int          CTRL_TGATE    = 3;
    localparam int          CTRL_STEPMODE = 4;
    localparam int          CTRL_W        = 5;
    localparam logic [4:0]  CTRL_RESET    = 5'h03;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int          STAT_COUNT_LSB = 0;
    localparam int          STAT_TC        = 4;

    // ------------------------------------------------------------------
    // Counter stage and timing
    // ------------------------------------------------------------------
    localparam int          STAGE_W        = 4;
    localparam logic [3:0]  COUNT_MAX      = 4'hF;
    localparam logic [3:0]  COUNT_ZERO     = 4'h0;
    localparam int          PRESCALE_W     = 16;
    localparam logic [15:0] PRESCALE_RESET = 16'h0018;
    localparam int          STEP_BIT       = 0;

    // Toggle mask: bit 0 always toggles, each higher bit only when all
    // lower bits are set; gives ordinary binary weighting
    function automatic logic [3:0] toggle_mask(input logic [3:0] q);
        logic [3:0] t;
        t = 4'h1;
        for (int i = 1; i < 4; i++) begin
            t[i] = t[i-1] & q[i-1];
        end
        return t;
    endfunction

endpackage
`default_nettype wire

// ==== counter_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module counter_stage
    import counter_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // Count clock enable
    input  wire logic       count_clock_in,
    // Controls
    input  wire logic       master_clear_n_in,
    input  wire logic       load_control_n_in,
    input  wire logic       parallel_count_gate_in,
    input  wire logic       trickle_count_gate_in,
    input  wire logic [3:0] preset_inputs_in,
    // Results
    output logic [3:0]      count_outputs_out,
    output logic            terminal_count_flag_out
);

    // ------------------------------------------------------------------
    // Counter flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in || !master_clear_n_in) begin
            // Clear does not wait for a count clock edge
            count_outputs_out <= COUNT_ZERO;
        end else if (count_clock_in) begin
            if (!load_control_n_in) begin
                count_outputs_out <= preset_inputs_in;
            end else if (parallel_count_gate_in && trickle_count_gate_in) begin
                count_outputs_out <= count_outputs_out
                    ^ toggle_mask(count_outputs_out);
            end
        end
    end

    // Combinational so that a chained stage sees it on the same edge
    assign terminal_count_flag_out = (count_outputs_out == COUNT_MAX)
                                   && trickle_count_gate_in;

endmodule
`default_nettype wire

// ==== presettable_binary_counter.sv ====
// Summary of operation
// - Master clear low forces all counter bits to zero; counting needs it high.
// - Load control low loads the preset inputs, ignoring both count gates.
// - Count only with load high and both gates high; otherwise hold.
// - Every counter state change except master clear happens on a count clock edge.
// - Counting starts from zero after clear or from the loaded preset.
// - Straight binary count to 15 in each stage, flagged on the terminal-count output when all stages are at 15 and the first stage's trickle gate is high.
// - Bit 0 toggles each enabled edge; higher bits when lower bits set.
// - Terminal count of one stage feeds the trickle gate of the next.
`timescale 1ns/1ps
`default_nettype none
module presettable_binary_counter
#(
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         srst_in,
    // APB slave
    input  wire logic                         psel_in,
    input  wire logic                         penable_in,
    input  wire logic                         pwrite_in,
    input  wire logic [counter_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]                  pwdata_in,
    output logic [31:0]                       prdata_out,
    output logic                              pready_out,
    output logic                              pslverr_out,
    // Counter results
    output logic [3:0]                        count_outputs_out,
    output logic                              terminal_count_flag_out
);
    import counter_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0]       ctrl_r;
    logic [3:0]              preset_r;
    logic [PRESCALE_W-1:0]   prescale_r;
    logic                    step_r;
    logic                    tick;
    logic                    count_clock;
    logic                    master_clear_n;
    logic                    load_control_n;
    logic                    parallel_count_gate;
    logic [STAGES-1:0]       trickle_in;
    logic [STAGES-1:0]       tc;
    logic [4*STAGES-1:0]     count_all;
    logic                    access;
    logic                    wr_en;
    logic                    rd_phase;
    logic                    mapped;
    logic [31:0]             rdata_nxt;

    assign master_clear_n      = ctrl_r[CTRL_CLEAR_N];
    assign load_control_n      = ctrl_r[CTRL_LOAD_N];
    assign parallel_count_gate = ctrl_r[CTRL_PGATE];

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle. The extra
    // cycle lets read data come straight from a flip-flop.
    assign access   = psel_in && penable_in;
    assign rd_phase = access && !pready_out;
    assign wr_en    = access && pready_out && pwrite_in && mapped;

    always_comb begin
        mapped = 1'b1;
        case (paddr_in)
            OFF_CTRL, OFF_PRESET, OFF_PRESCALE, OFF_STEP,
            OFF_STATUS, OFF_COUNT_ALL: mapped = 1'b1;
            default:                   mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pready_out <= 1'b0;
        end else begin
            pready_out <= rd_phase;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pslverr_out <= 1'b0;
        end else begin
            pslverr_out <= rd_phase && !mapped;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr_in)
            OFF_CTRL:      rdata_nxt[CTRL_W-1:0]     = ctrl_r;
            OFF_PRESET:    rdata_nxt[3:0]            = preset_r;
            OFF_PRESCALE:  rdata_nxt[PRESCALE_W-1:0] = prescale_r;
            OFF_STATUS: begin
                rdata_nxt[STAT_COUNT_LSB +: 4] = count_all[3:0];
                rdata_nxt[STAT_TC]             = tc[STAGES-1];
            end
            OFF_COUNT_ALL: rdata_nxt[4*STAGES-1:0]   = count_all;
            default:       rdata_nxt                 = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (rd_phase) begin
            prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_en && paddr_in == OFF_CTRL) begin
            ctrl_r <= pwdata_in[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            preset_r <= COUNT_ZERO;
        end else if (wr_en && paddr_in == OFF_PRESET) begin
            preset_r <= pwdata_in[3:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prescale_r <= PRESCALE_RESET;
        end else if (wr_en && paddr_in == OFF_PRESCALE) begin
            prescale_r <= pwdata_in[PRESCALE_W-1:0];
        end
    end

    // Step is a one-cycle count clock edge requested by software
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            step_r <= 1'b0;
        end else begin
            step_r <= wr_en && paddr_in == OFF_STEP
                   && pwdata_in[STEP_BIT] && ctrl_r[CTRL_STEPMODE];
        end
    end

    // ------------------------------------------------------------------
    // Count clock source
    // ------------------------------------------------------------------
    count_prescaler #(
        .WIDTH     (PRESCALE_W)
    ) u_prescaler (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .run_in    (!ctrl_r[CTRL_STEPMODE]),
        .reload_in (prescale_r),
        .tick_out  (tick)
    );

    assign count_clock = ctrl_r[CTRL_STEPMODE] ? step_r : tick;

    // ------------------------------------------------------------------
    // Cascaded stages
    // ------------------------------------------------------------------
    // Rippled terminal count limits the chain length at speed; at the
    // enable rates used here a long chain is harmless.
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            if (g == 0) begin : g_first
                assign trickle_in[g] = ctrl_r[CTRL_TGATE];
            end else begin : g_next
                assign trickle_in[g] = tc[g-1];
            end
            counter_stage u_stage (
                .clk_in                  (clk_in),
                .srst_in                 (srst_in),
                .count_clock_in          (count_clock),
                .master_clear_n_in       (master_clear_n),
                .load_control_n_in       (load_control_n),
                .parallel_count_gate_in  (parallel_count_gate),
                .trickle_count_gate_in   (trickle_in[g]),
                .preset_inputs_in        (preset_r),
                .count_outputs_out       (count_all[4*g +: 4]),
                .terminal_count_flag_out (tc[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_outputs_out <= COUNT_ZERO;
        end else begin
            count_outputs_out <= count_all[3:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            terminal_count_flag_out <= 1'b0;
        end else begin
            terminal_count_flag_out <= tc[STAGES-1];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    property p_clear;
        !master_clear_n |=> count_all == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("Counter not zero after master clear");

    property p_load;
        count_clock && master_clear_n && !load_control_n
            |=> count_all[3:0] == $past(preset_r);
    endproperty
    a_load: assert property (p_load)
        else $error("Preset value not loaded");

    property p_hold;
        count_clock && master_clear_n && load_control_n
            && !(parallel_count_gate && trickle_in[0])
            |=> $stable(count_all[3:0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Count changed with a gate low");

    property p_edge_only;
        !count_clock && master_clear_n |=> $stable(count_all);
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("Count changed without a count clock edge");

    property p_increment;
        count_clock && master_clear_n && load_control_n
            && parallel_count_gate && trickle_in[0]
            |=> count_all[3:0] == 4'($past(count_all[3:0]) + 4'h1);
    endproperty
    a_increment: assert property (p_increment)
        else $error("Count did not advance by one");

    property p_lsb_toggle;
        count_clock && master_clear_n && load_control_n
            && parallel_count_gate && trickle_in[0]
            |=> count_all[0] != $past(count_all[0]);
    endproperty
    a_lsb_toggle: assert property (p_lsb_toggle)
        else $error("Least significant bit did not toggle");

    property p_tc_out;
        tc[STAGES-1] |=> terminal_count_flag_out ##1
            (terminal_count_flag_out == $past(tc[STAGES-1]));
    endproperty
    a_tc_out: assert property (p_tc_out)
        else $error("Terminal count output wrong");

    property p_tc_only_max;
        tc[0] |-> count_all[3:0] == COUNT_MAX && trickle_in[0];
    endproperty
    a_tc_only_max: assert property (p_tc_only_max)
        else $error("Terminal count outside count 15");

    generate
        if (STAGES > 1) begin : g_chain_chk
            property p_chain;
                $past(master_clear_n) && $past(load_control_n)
                    && count_all[7:4] != $past(count_all[7:4])
                    |-> $past(count_all[3:0]) == COUNT_MAX;
            endproperty
            a_chain: assert property (p_chain)
                else $error("Next stage advanced without carry");
        end
    endgenerate

    property p_clear_now;
        wr_en && paddr_in == OFF_CTRL && !pwdata_in[CTRL_CLEAR_N]
            |=> ##1 count_all == '0;
    endproperty
    a_clear_now: assert property (p_clear_now)
        else $error("Clear waited for a count clock edge");

    property p_apb_wait;
        psel_in && penable_in && !pready_out |=> pready_out;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("APB ready not given after one wait");

endmodule
`default_nettype wire

// ==== presettable_binary_counter_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module presettable_binary_counter_tb_top;
    import counter_pkg::*;
    logic        clk_in;
    logic        srst_in;
    logic        psel, penable, pwrite, pready, pslverr, tc;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  cnt;
    int          error_cnt = 0;
    int          check_count = 0;

    presettable_binary_counter #(.STAGES(2)) uut (
        .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .count_outputs_out(cnt),
        .terminal_count_flag_out(tc));

    apb_ctrl_host host (
        .clk_in(clk_in), .psel_out(psel), .penable_out(penable),
        .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
        .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b1, a, d, r, e);
        chk("write error flag", 32'h0, {31'h0, e});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
    endtask

    // Step pulse, then let the registered pin copy settle
    task automatic step();
        wr(OFF_STEP, 32'h1);
        repeat (3) @(posedge clk_in);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd(OFF_CTRL, 32'h3, "ctrl reset");
        rd(OFF_PRESET, 32'h0, "preset reset");
        rd(OFF_PRESCALE, 32'h18, "prescale reset");
        rd(OFF_STATUS, 32'h0, "status reset");
        chk("count pins reset", 32'h0, {28'h0, cnt});
        $display("test reset done");
    endtask

    task automatic t_apb();
        logic [31:0] r;
        logic        e;
        host.xfer(1'b0, 8'h18, 32'h0, r, e);
        chk("unmapped read err", 32'h1, {31'h0, e});
        chk("unmapped read data", 32'h0, r);
        host.xfer(1'b1, 8'h20, 32'h5, r, e);
        chk("unmapped write err", 32'h1, {31'h0, e});
        wr(OFF_STATUS, 32'h1F);
        rd(OFF_STATUS, 32'h0, "status read only");
        rd(OFF_STEP, 32'h0, "step reads zero");
        wr(OFF_PRESET, 32'hFFFF_FFFF);
        rd(OFF_PRESET, 32'hF, "preset width");
        $display("test apb done");
    endtask

    task automatic t_load();
        wr(OFF_CTRL, 32'h1F);
        wr(OFF_PRESET, 32'hC);
        wr(OFF_CTRL, 32'h11);
        rd(OFF_STATUS, 32'h0, "no load without tick");
        step();
        rd(OFF_STATUS, 32'hC, "load gates low");
        chk("count pins load", 32'hC, {28'h0, cnt});
        wr(OFF_CTRL, 32'h1F);
        step();
        rd(OFF_STATUS, 32'hD, "count from preset");
        // Load must also win over gates that are both high
        wr(OFF_CTRL, 32'h1D);
        step();
        rd(OFF_COUNT_ALL, 32'hCC, "load gates high");
        $display("test load done");
    endtask

    task automatic t_clear();
        wr(OFF_CTRL, 32'h1E);
        rd(OFF_COUNT_ALL, 32'h0, "clear no tick");
        step();
        rd(OFF_COUNT_ALL, 32'h0, "clear held");
        chk("count pins clear", 32'h0, {28'h0, cnt});
        $display("test clear done");
    endtask

    task automatic t_gates();
        for (int g = 0; g < 3; g++) begin
            wr(OFF_CTRL, 32'h13 | (g << 2));
            step();
            rd(OFF_COUNT_ALL, 32'h0, "gate hold");
        end
        $display("test gates done");
    endtask

    // Full run over both chained stages; trickle chain checked at 255
    task automatic t_wrap();
        wr(OFF_CTRL, 32'h1F);
        for (int i = 0; i < 256; i++) begin
            rd(OFF_COUNT_ALL, 32'(i), "count all");
            rd(OFF_STATUS, {27'h0, i == 255, i[3:0]}, "status");
            chk("count pins", {28'h0, i[3:0]}, {28'h0, cnt});
            chk("tc pin", {31'h0, i == 255}, {31'h0, tc});
            if (i < 255) step();
        end
        wr(OFF_CTRL, 32'h17);
        rd(OFF_STATUS, 32'h0F, "tc needs trickle");
        step();
        rd(OFF_COUNT_ALL, 32'hFF, "trickle low hold");
        chk("tc pin trickle low", 32'h0, {31'h0, tc});
        wr(OFF_CTRL, 32'h1F);
        step();
        rd(OFF_COUNT_ALL, 32'h0, "wrap to zero");
        $display("test wrap done");
    endtask

    // Count changes only on prescaler ticks, PRESCALE+1 clocks apart
    task automatic t_prescale();
        logic [3:0] prev;
        int         n;
        wr(OFF_PRESCALE, 32'h3);
        rd(OFF_PRESCALE, 32'h3, "prescale rw");
        wr(OFF_CTRL, 32'h0F);
        prev = cnt;
        n = 0;
        while (cnt === prev && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        prev = cnt;
        n = 0;
        while (cnt === prev && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        chk("tick spacing", 32'h4, 32'(n));
        wr(OFF_CTRL, 32'h1E);
        $display("test prescale done");
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, sequence, watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    initial begin
        srst_in = 1'b1;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_apb();
        t_load();
        t_clear();
        t_gates();
        t_wrap();
        t_prescale();
        give_verdict();
    end

    // Whole sequence needs under 10k clocks; allow a wide margin
    initial begin
        repeat (40000) @(posedge clk_in);
        error_cnt++;
        $display("MISMATCH watchdog expected done seen hang");
        give_verdict();
    end
endmodule
`default_nettype wire
